// [verilog/qrt_timer.sv]
// Quad 8-bit reload down timer with AHB-Lite register slave
// Function
// - pair mode bit chains two 8-bit timers
// - divider code picks count clock
// - 16-bit pair uses low timer divider
// - event mode ignores timer 0 divider
// - source bit selects event pin counting
// - filter bit routes pin through rejector
// - polarity bit picks rising or falling edge
// - reload on command and every underflow
// - count readable as nibbles, writes ignored
// - reload command presets counter, reads zero
// - 16-bit reload from low timer only
// - run bit starts, stops, keeps count
// - 16-bit run from low timer only
// - run/stop at count clock edge
// - channel field picks pulse source timer
// - output enable gates pulse onto pin
// - per-timer interrupt mask bits
// - underflow sets flag, write one clears
// - 16-bit low timer flag stays clear
`timescale 1ns/1ps
module qrt_timer
    import qrt_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        event_input_pin,
    output logic             shared_output_pin,
    output logic      [3:0]  timer_irq
);

    logic [1:0]  pair_mode_r;
    logic [2:0]  src_cfg_r;
    logic [2:0]  pout_cfg_r;
    qrt_tcfg_t   cfg_r [4];
    logic [3:0]  run_act_r;
    logic [7:0]  rld_r [4];
    logic [7:0]  cnt_r [4];
    logic [7:0]  hold_r [4];
    logic [7:0]  cnt_nxt [4];
    logic [3:0]  irq_en_r;
    logic [3:0]  irq_flag_r;
    logic [3:0]  irq_flag_nxt;
    logic [3:0]  timer_irq_r;
    logic        pulse_lvl_r;
    logic        pin_r;
    qrt_wr_t     wr_r;
    logic [31:0] hrdata_r;
    logic        hreadyout_r;
    logic        hresp_r;
    logic [7:0]  pre_r;
    logic        ev_s1_r;
    logic        ev_s2_r;
    logic        ev_filt_r;
    logic        ev_prev_r;
    logic [2:0]  nr_cnt_r;
    logic        ev_sel;
    logic        ev_tick;
    logic [3:0]  own_tick;
    logic [3:0]  eff_tick;
    logic [3:0]  dec;
    logic [3:0]  cmd;
    logic [3:0]  ufl;
    logic [3:0]  wr_ctrl;
    logic [3:0]  wd;
    logic        rd_acc;
    logic        addr_ok;
    logic [15:0] a_idx;
    logic [3:0]  rd_val;

    // True on the cycle before the divided clock falls
    function automatic logic div_tick(input logic [1:0] code, input logic [7:0] pre);
        logic [3:0] k;
        logic [7:0] mask;
        case (code)
            2'h3:    k = DIV_CODE11_LOG2;
            2'h2:    k = DIV_CODE10_LOG2;
            2'h1:    k = DIV_CODE01_LOG2;
            default: k = DIV_CODE00_LOG2;
        endcase
        mask = 8'((9'h001 << k) - 9'h001);
        return (pre & mask) == mask;
    endfunction

    function automatic logic is_m16(input logic [1:0] pm, input int i);
        return pm[i / 2];
    endfunction

    assign wd      = hwdata[3:0];
    assign a_idx   = haddr[17:2];
    assign addr_ok = haddr[31:18] == 14'h0000;
    assign rd_acc  = hsel && htrans[1] && hready && !hwrite && addr_ok;

    // Prescaler off the oscillation clock
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pre_r <= RST_BYTE;
        end else begin
            pre_r <= pre_r + 8'h01;
        end
    end

    // Pin synchroniser and noise rejector
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ev_s1_r   <= 1'b0;
            ev_s2_r   <= 1'b0;
            ev_filt_r <= 1'b0;
            ev_prev_r <= 1'b0;
            nr_cnt_r  <= 3'h0;
        end else begin
            ev_s1_r   <= event_input_pin;
            ev_s2_r   <= ev_s1_r;
            ev_prev_r <= ev_sel;
            if (ev_s2_r != ev_filt_r) begin
                if (nr_cnt_r == NR_CYCLES - 3'h1) begin
                    ev_filt_r <= ev_s2_r;
                    nr_cnt_r  <= 3'h0;
                end else begin
                    nr_cnt_r <= nr_cnt_r + 3'h1;
                end
            end else begin
                nr_cnt_r <= 3'h0;
            end
        end
    end

    assign ev_sel  = src_cfg_r[SRC_FILT_BIT] ? ev_filt_r : ev_s2_r;
    assign ev_tick = src_cfg_r[SRC_POL_BIT] ? (ev_sel && !ev_prev_r) : (!ev_sel && ev_prev_r);

    // Count engine
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            own_tick[i] = div_tick(cfg_r[i].div, pre_r);
            wr_ctrl[i]  = wr_r.valid && (wr_r.idx == IDX_CTRL[i]);
        end
        if (src_cfg_r[SRC_EVT_BIT]) begin
            own_tick[0] = ev_tick;
        end
        for (int i = 0; i < 4; i++) begin
            eff_tick[i] = is_m16(pair_mode_r, i) ? own_tick[i & 2] : own_tick[i];
            dec[i]      = eff_tick[i] && (is_m16(pair_mode_r, i) ? run_act_r[i & 2] : run_act_r[i]);
            cmd[i]      = wr_ctrl[i] && wd[CTRL_CMD_BIT] && !(is_m16(pair_mode_r, i) && i[0]);
        end
        for (int p = 0; p < 4; p += 2) begin
            if (pair_mode_r[p / 2]) begin
                ufl[p]       = 1'b0;
                ufl[p + 1]   = dec[p] && cnt_r[p] == 8'h00 && cnt_r[p + 1] == 8'h00;
                if (cmd[p] || ufl[p + 1]) begin
                    cnt_nxt[p]     = rld_r[p];
                    cnt_nxt[p + 1] = rld_r[p + 1];
                end else begin
                    cnt_nxt[p]     = dec[p] ? cnt_r[p] - 8'h01 : cnt_r[p];
                    cnt_nxt[p + 1] = (dec[p] && cnt_r[p] == 8'h00) ? cnt_r[p + 1] - 8'h01 : cnt_r[p + 1];
                end
            end else begin
                for (int j = p; j < p + 2; j++) begin
                    ufl[j] = dec[j] && cnt_r[j] == 8'h00;
                    if (cmd[j] || ufl[j]) begin
                        cnt_nxt[j] = rld_r[j];
                    end else begin
                        cnt_nxt[j] = dec[j] ? cnt_r[j] - 8'h01 : cnt_r[j];
                    end
                end
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < 4; i++) begin
                cnt_r[i] <= RST_BYTE;
            end
            run_act_r <= RST_NIBBLE;
        end else begin
            for (int i = 0; i < 4; i++) begin
                cnt_r[i] <= cnt_nxt[i];
                // Stop lands only with the decrement at this edge
                if (is_m16(pair_mode_r, i) && i[0]) begin
                    run_act_r[i] <= 1'b0;
                end else if (own_tick[i]) begin
                    run_act_r[i] <= cfg_r[i].run_req;
                end
            end
        end
    end

    // Register writes, data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pair_mode_r <= 2'h0;
            src_cfg_r   <= 3'h0;
            pout_cfg_r  <= 3'h0;
            irq_en_r    <= RST_NIBBLE;
            for (int i = 0; i < 4; i++) begin
                cfg_r[i] <= '0;
                rld_r[i] <= RST_BYTE;
            end
        end else if (wr_r.valid) begin
            if (wr_r.idx == IDX_PAIR_MODE) begin
                pair_mode_r <= wd[1:0];
            end
            if (wr_r.idx == IDX_T0_SRC) begin
                src_cfg_r <= wd[2:0];
            end
            if (wr_r.idx == IDX_POUT) begin
                pout_cfg_r <= wd[2:0];
            end
            if (wr_r.idx == IDX_IRQ_EN) begin
                irq_en_r <= wd;
            end
            for (int i = 0; i < 4; i++) begin
                if (wr_ctrl[i] && !(is_m16(pair_mode_r, i) && i[0])) begin
                    cfg_r[i].div     <= wd[CTRL_DIV_LSB +: 2];
                    cfg_r[i].run_req <= wd[CTRL_RUN_BIT];
                end
                if (wr_r.idx == IDX_RLD_LO[i]) begin
                    rld_r[i][3:0] <= wd;
                end
                if (wr_r.idx == IDX_RLD_HI[i]) begin
                    rld_r[i][7:4] <= wd;
                end
            end
        end
    end

    // Flags: a set in the clearing cycle wins
    assign irq_flag_nxt = (irq_flag_r & ~((wr_r.valid && wr_r.idx == IDX_IRQ_FLAG) ? wd : 4'h0)) | ufl;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_flag_r  <= RST_NIBBLE;
            timer_irq_r <= RST_NIBBLE;
        end else begin
            irq_flag_r  <= irq_flag_nxt;
            timer_irq_r <= irq_flag_r & irq_en_r;
        end
    end

    // Pulse output
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pulse_lvl_r <= 1'b0;
            pin_r       <= 1'b1;
        end else begin
            if (ufl[pout_cfg_r[POUT_CH_LSB +: 2]]) begin
                pulse_lvl_r <= !pulse_lvl_r;
            end
            pin_r <= pout_cfg_r[POUT_EN_BIT] ? pulse_lvl_r : 1'b1;
        end
    end

    // Read mux, address phase
    always_comb begin
        rd_val = RD_UNMAPPED;
        case (a_idx)
            IDX_PAIR_MODE: rd_val = {2'h0, pair_mode_r};
            IDX_T0_SRC:    rd_val = {1'b0, src_cfg_r};
            IDX_POUT:      rd_val = {1'b0, pout_cfg_r};
            IDX_IRQ_EN:    rd_val = irq_en_r;
            IDX_IRQ_FLAG:  rd_val = irq_flag_r;
            default:       rd_val = RD_UNMAPPED;
        endcase
        for (int i = 0; i < 4; i++) begin
            if (a_idx == IDX_CTRL[i]) begin
                rd_val = {cfg_r[i].div, 1'b0, cfg_r[i].run_req || run_act_r[i]};
            end
            if (a_idx == IDX_RLD_LO[i]) begin
                rd_val = rld_r[i][3:0];
            end
            if (a_idx == IDX_RLD_HI[i]) begin
                rd_val = rld_r[i][7:4];
            end
            if (a_idx == IDX_CNT_LO[i]) begin
                rd_val = (is_m16(pair_mode_r, i) && i[0]) ? hold_r[i][3:0] : cnt_r[i][3:0];
            end
            if (a_idx == IDX_CNT_HI[i]) begin
                rd_val = hold_r[i][7:4];
            end
        end
    end

    // Low nibble read freezes the rest so a multi-read is coherent
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < 4; i++) begin
                hold_r[i] <= RST_BYTE;
            end
        end else if (rd_acc) begin
            for (int i = 0; i < 4; i++) begin
                if (a_idx == IDX_CNT_LO[i] && !(is_m16(pair_mode_r, i) && i[0])) begin
                    hold_r[i] <= cnt_r[i];
                    if (is_m16(pair_mode_r, i)) begin
                        // Odd partner; also keeps the index in range when unrolled
                        hold_r[i | 1] <= cnt_r[i | 1];
                    end
                end
            end
        end
    end

    // AHB-Lite slave, zero wait states, always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_r        <= '0;
            hrdata_r    <= 32'h0000_0000;
            hreadyout_r <= 1'b1;
            hresp_r     <= 1'b0;
        end else begin
            hreadyout_r <= 1'b1;
            hresp_r     <= 1'b0;
            if (hready) begin
                wr_r.valid <= hsel && htrans[1] && hwrite && addr_ok;
                wr_r.idx   <= a_idx;
            end
            if (rd_acc) begin
                hrdata_r <= {28'h0000000, rd_val};
            end
        end
    end

    assign hrdata            = hrdata_r;
    assign hreadyout         = hreadyout_r;
    assign hresp             = hresp_r;
    assign shared_output_pin = pin_r;
    assign timer_irq         = timer_irq_r;

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_flag_set_wins: assert property (ufl[1] |=> irq_flag_r[1])
        else $error("underflow lost flag");
    a_low_flag_clear: assert property (pair_mode_r[0] && !irq_flag_r[0] |=> !irq_flag_r[0])
        else $error("low timer flag in 16-bit mode");
    a_cmd_reads_zero: assert property (rd_acc && a_idx == IDX_CTRL[0] |=> hrdata[CTRL_CMD_BIT] == 1'b0)
        else $error("reload command read not zero");
    a_reload_loads: assert property (cmd[0] && !pair_mode_r[0] |=> cnt_r[0] == $past(rld_r[0]))
        else $error("reload command did not load");
    a_stop_after_dec: assert property ($fell(run_act_r[0]) |-> $past(dec[0]))
        else $error("stop without final decrement");
    a_run_reads_one: assert property (run_act_r[2] && rd_acc && a_idx == IDX_CTRL[2] |=> hrdata[0])
        else $error("run bit read zero while running");
    a_pin_idle_high: assert property (!pout_cfg_r[POUT_EN_BIT] [*2] |-> shared_output_pin)
        else $error("pin not high while disabled");
    a_pulse_toggle: assert property (ufl[pout_cfg_r[1:0]] |=> ##1 shared_output_pin != $past(shared_output_pin)
                                     || !$past(pout_cfg_r[POUT_EN_BIT])
                                     || !$past(pout_cfg_r[POUT_EN_BIT], 2))
        else $error("pulse did not toggle");
    a_irq_gate: assert property (##1 timer_irq == $past(irq_flag_r & irq_en_r))
        else $error("interrupt request mismatch");
    a_ro_count: assert property (wr_r.valid && wr_r.idx == IDX_CNT_LO[3] && !dec[3] && !cmd[3]
                                 && !pair_mode_r[1] |=> cnt_r[3] == $past(cnt_r[3]))
        else $error("count changed by write");

    c_16bit_underflow: cover property (pair_mode_r[0] && ufl[1]);
    c_event_tick: cover property (src_cfg_r[SRC_EVT_BIT] && dec[0]);
    c_flag_clear: cover property (irq_flag_r[0] ##1 !irq_flag_r[0]);
    c_pin_toggle: cover property (pout_cfg_r[POUT_EN_BIT] && $changed(shared_output_pin));

endmodule

// [verilog/qrt_pkg.sv]
// Package for the quad reload down timer: register map, fields, resets, types
package qrt_pkg;

    // Register indices; byte address is four times the index
    localparam logic [15:0] IDX_PAIR_MODE = 16'hFFC0;
    localparam logic [15:0] IDX_T0_SRC    = 16'hFFC1;
    localparam logic [15:0] IDX_POUT      = 16'hFFC2;
    localparam logic [15:0] IDX_IRQ_EN    = 16'hFFE2;
    localparam logic [15:0] IDX_IRQ_FLAG  = 16'hFFF2;
    localparam logic [15:0] IDX_CTRL   [4] = '{16'hFFC4, 16'hFFC5, 16'hFFC6, 16'hFFC7};
    localparam logic [15:0] IDX_RLD_LO [4] = '{16'hFFD0, 16'hFFD2, 16'hFFD4, 16'hFFD6};
    localparam logic [15:0] IDX_RLD_HI [4] = '{16'hFFD1, 16'hFFD3, 16'hFFD5, 16'hFFD7};
    localparam logic [15:0] IDX_CNT_LO [4] = '{16'hFFD8, 16'hFFDA, 16'hFFDC, 16'hFFDE};
    localparam logic [15:0] IDX_CNT_HI [4] = '{16'hFFD9, 16'hFFDB, 16'hFFDD, 16'hFFDF};

    // Field positions
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_CMD_BIT = 1;
    localparam int CTRL_DIV_LSB = 2;
    localparam int SRC_POL_BIT  = 0;
    localparam int SRC_FILT_BIT = 1;
    localparam int SRC_EVT_BIT  = 2;
    localparam int POUT_CH_LSB  = 0;
    localparam int POUT_EN_BIT  = 2;

    // Reset values
    localparam logic [3:0] RST_NIBBLE = 4'h0;
    localparam logic [7:0] RST_BYTE   = 8'h00;

    // Divider: log2 of the division ratio per code
    localparam logic [3:0] DIV_CODE11_LOG2 = 4'h8;
    localparam logic [3:0] DIV_CODE10_LOG2 = 4'h5;
    localparam logic [3:0] DIV_CODE01_LOG2 = 4'h2;
    localparam logic [3:0] DIV_CODE00_LOG2 = 4'h1;

    // Noise rejector: cycles an input level must hold
    localparam logic [2:0] NR_CYCLES = 3'h4;

    // Unmapped reads
    localparam logic [3:0] RD_UNMAPPED = 4'h0;

    typedef struct packed {
        logic [1:0] div;
        logic       run_req;
    } qrt_tcfg_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] idx;
    } qrt_wr_t;

endpackage

// [bench/qrt_timer_tb.sv]
// Self-checking testbench for the quad reload down timer over AHB-Lite
`timescale 1ns/1ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin errors++; \
    $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp); end end
module qrt_timer_tb
    import qrt_pkg::*;
;
    localparam logic [15:0] SGL [6] = '{IDX_PAIR_MODE, IDX_T0_SRC, IDX_POUT, IDX_IRQ_EN, IDX_IRQ_FLAG, 16'hFFC3};
    localparam logic [3:0]  MSK [4] = '{4'h3, 4'h7, 4'h7, 4'hF};
    logic        hclk    = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel    = 1'b0;
    logic [31:0] haddr   = 32'h0;
    logic [1:0]  htrans  = 2'h0;
    logic        hwrite  = 1'b0;
    logic [2:0]  hsize   = 3'h2;
    logic [31:0] hwdata  = 32'h0;
    logic        ev_pin  = 1'b0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        pin;
    logic [3:0]  irq;
    logic [3:0]  r;
    logic [7:0]  c;
    logic [7:0]  c2;
    logic [7:0]  c_t1;
    logic        pin0;
    int          k;
    int          d;
    int          errors      = 0;
    int          comparisons = 0;

    qrt_timer i_dut (
        .hclk              (hclk),
        .hresetn           (hresetn),
        .hsel              (hsel),
        .haddr             (haddr),
        .htrans            (htrans),
        .hwrite            (hwrite),
        .hsize             (hsize),
        .hwdata            (hwdata),
        .hready            (hreadyout),
        .hrdata            (hrdata),
        .hreadyout         (hreadyout),
        .hresp             (hresp),
        .event_input_pin   (ev_pin),
        .shared_output_pin (pin),
        .timer_irq         (irq)
    );

    always #25 hclk = ~hclk;

    task automatic print_verdict();
        if (errors == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Single transfer; address phase held until hready, then data phase until hready
    task automatic ahb(input logic wr, input logic [15:0] idx, input logic [3:0] wd, output logic [3:0] rd);
        hsel   <= 1'b1;
        haddr  <= {14'h0, idx, 2'h0};
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {28'h0, wd};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata[3:0];
    endtask

    task automatic wr(input logic [15:0] idx, input logic [3:0] wd);
        logic [3:0] dummy;
        ahb(1'b1, idx, wd, dummy);
    endtask

    task automatic rd(input logic [15:0] idx, output logic [3:0] v);
        ahb(1'b0, idx, 4'h0, v);
    endtask

    // Low nibble first, it latches the byte
    task automatic rdc(input int t, output logic [7:0] v);
        rd(IDX_CNT_LO[t], v[3:0]);
        rd(IDX_CNT_HI[t], v[7:4]);
    endtask

    task automatic stop(input int t, input logic [1:0] div);
        wr(IDX_CTRL[t], {div, 2'h0});
        for (int i = 0; i < 300; i++) begin
            rd(IDX_CTRL[t], r);
            if (r[0] === 1'b0) break;
        end
        `CHK(r[0], 1'b0)
    endtask

    task automatic measure(input int t, input logic [1:0] div, input logic [7:0] rl, input int w,
                           output logic [7:0] v);
        wr(IDX_RLD_LO[t], rl[3:0]);
        wr(IDX_RLD_HI[t], rl[7:4]);
        wr(IDX_CTRL[t], {div, 2'h3});
        rd(IDX_CTRL[t], r);
        `CHK(r, {div, 2'h1})
        repeat (w) @(posedge hclk);
        stop(t, div);
        rdc(t, v);
    endtask

    task automatic toggles(input int n, output int cnt);
        logic p;
        cnt = 0;
        p = pin;
        repeat (n) begin
            @(posedge hclk);
            #1;
            if (pin !== p) cnt++;
            p = pin;
        end
    endtask

    task automatic pulses(input int hi, input int lo, input int n);
        repeat (n) begin
            ev_pin <= 1'b1;
            repeat (hi) @(posedge hclk);
            ev_pin <= 1'b0;
            repeat (lo) @(posedge hclk);
        end
    endtask

    initial begin
        #(30000 * 50);
        errors++;
        print_verdict();
    end

    initial begin
        repeat (16) @(posedge hclk);
        `CHK(pin, 1'b1)
        `CHK(irq, 4'h0)
        hresetn <= 1'b1;
        @(posedge hclk);
        // Reset values, unmapped place included
        for (int i = 0; i < 6; i++) begin
            rd(SGL[i], r);
            `CHK(r, RST_NIBBLE)
        end
        for (int t = 0; t < 4; t++) begin
            rd(IDX_CTRL[t], r);
            `CHK(r, RST_NIBBLE)
            rd(IDX_RLD_LO[t], r);
            `CHK(r, RST_NIBBLE)
            rd(IDX_RLD_HI[t], r);
            `CHK(r, RST_NIBBLE)
            rdc(t, c);
            `CHK(c, RST_BYTE)
        end
        for (int i = 0; i < 4; i++) begin
            wr(SGL[i], MSK[i]);
            rd(SGL[i], r);
            `CHK(r, MSK[i])
            wr(SGL[i], 4'h0);
        end
        wr(SGL[5], 4'hF);
        rd(SGL[5], r);
        `CHK(r, RD_UNMAPPED)
        `CHK(hresp, 1'b0)
        for (int t = 0; t < 4; t++) begin
            wr(IDX_RLD_LO[t], 4'(t + 5));
            rd(IDX_RLD_LO[t], r);
            `CHK(r, 4'(t + 5))
            wr(IDX_CNT_LO[t], 4'hF);
            rd(IDX_CNT_LO[t], r);
            `CHK(r, RST_NIBBLE)
        end
        // Preset while stopped is held
        wr(IDX_RLD_LO[1], 4'hA);
        wr(IDX_RLD_HI[1], 4'h5);
        wr(IDX_CTRL[1], 4'h2);
        rd(IDX_CTRL[1], r);
        `CHK(r, 4'h0)
        repeat (50) @(posedge hclk);
        rdc(1, c);
        `CHK(c, 8'h5A)
        measure(1, 2'h0, 8'h5A, 20, c_t1);
        `CHK((c_t1 >= 8'h48 && c_t1 <= 8'h52), 1'b1)
        repeat (30) @(posedge hclk);
        rdc(1, c2);
        `CHK(c2, c_t1)
        // Divider codes 10 and 11
        for (int dv = 2; dv < 4; dv++) begin
            measure(3, 2'(dv), 8'hFF, 640, c);
            d = (dv == 3) ? 640 / 256 : 640 / 32;
            `CHK((c >= 8'(255 - d - 3) && c <= 8'(255 - d + 1)), 1'b1)
        end
        // Underflow pulse, flag, mask
        wr(IDX_RLD_LO[2], 4'h3);
        wr(IDX_RLD_HI[2], 4'h0);
        wr(IDX_POUT, 4'h6);
        wr(IDX_CTRL[2], 4'h3);
        toggles(80, k);
        `CHK((k >= 5), 1'b1)
        wr(IDX_POUT, 4'h2);
        repeat (4) @(posedge hclk);
        toggles(40, k);
        `CHK(k, 0)
        `CHK(pin, 1'b1)
        wr(IDX_POUT, 4'h4);
        repeat (4) @(posedge hclk);
        toggles(40, k);
        `CHK(k, 0)
        rd(IDX_IRQ_FLAG, r);
        `CHK(r[2], 1'b1)
        `CHK(irq[2], 1'b0)
        wr(IDX_IRQ_EN, 4'h4);
        repeat (3) @(posedge hclk);
        `CHK(irq[2], 1'b1)
        stop(2, 2'h0);
        wr(IDX_IRQ_FLAG, 4'h0);
        rd(IDX_IRQ_FLAG, r);
        `CHK(r[2], 1'b1)
        wr(IDX_IRQ_FLAG, 4'h4);
        rd(IDX_IRQ_FLAG, r);
        `CHK(r[2], 1'b0)
        repeat (2) @(posedge hclk);
        `CHK(irq[2], 1'b0)
        wr(IDX_IRQ_EN, 4'h0);
        wr(IDX_IRQ_FLAG, 4'hF);
        // Chained pair 0/1, value 0102
        wr(IDX_PAIR_MODE, 4'h1);
        wr(IDX_RLD_LO[0], 4'h2);
        wr(IDX_RLD_HI[0], 4'h0);
        wr(IDX_RLD_LO[1], 4'h1);
        wr(IDX_RLD_HI[1], 4'h0);
        wr(IDX_CTRL[1], 4'hF);
        rd(IDX_CTRL[1], r);
        `CHK(r, 4'h0)
        rdc(0, c);
        rdc(1, c);
        `CHK(c, c_t1)
        wr(IDX_CTRL[0], 4'h2);
        rdc(0, c);
        `CHK(c, 8'h02)
        rdc(1, c);
        `CHK(c, 8'h01)
        wr(IDX_POUT, 4'h5);
        repeat (2) @(posedge hclk);
        pin0 = pin;
        wr(IDX_CTRL[0], 4'h1);
        for (int i = 0; i < 600; i++) begin
            rd(IDX_IRQ_FLAG, r);
            if (r[1] === 1'b1) break;
        end
        `CHK(r[1], 1'b1)
        `CHK(r[0], 1'b0)
        `CHK(pin, !pin0)
        stop(0, 2'h0);
        wr(IDX_IRQ_FLAG, 4'hF);
        wr(IDX_PAIR_MODE, 4'h0);
        // Event counting; slow divider code must not matter
        wr(IDX_RLD_LO[0], 4'h0);
        wr(IDX_RLD_HI[0], 4'h1);
        wr(IDX_T0_SRC, 4'h5);
        wr(IDX_CTRL[0], 4'hF);
        pulses(4, 4, 6);
        repeat (8) @(posedge hclk);
        rdc(0, c);
        `CHK((c >= 8'h0A && c <= 8'h0B), 1'b1)
        wr(IDX_T0_SRC, 4'h6);
        pulses(1, 7, 6);
        repeat (8) @(posedge hclk);
        rdc(0, c2);
        `CHK(c2, c)
        pulses(8, 8, 6);
        repeat (8) @(posedge hclk);
        rdc(0, c2);
        `CHK(c2, 8'(c - 8'h06))
        print_verdict();
    end
endmodule
